// file: design/fault_regs_pkg.sv
// package: offsets, field positions, reset values and timing for the fault registers
package fault_regs_pkg;
   localparam logic [7:0] flags_addr = 8'h16;
   localparam logic [7:0] latch_cfg_addr = 8'h01;
   localparam int rfc_enable_bit = 7;
   localparam int phase_enable_bit = 6;
   localparam int thermal_warning_bit = 7;
   localparam int output_good_bit = 6;
   localparam logic [7:0] latch_cfg_reset = 8'h7f;
   localparam logic [7:0] flags_reset = 8'hbf;
   localparam int clk_mhz = 100;
   localparam int retry_ms = 130;
   localparam int retry_cycles = retry_ms * 1000 * clk_mhz;

   // turn-off style encodings
   localparam logic [1:0] off_sequenced = 2'h0;
   localparam logic [1:0] off_critical = 2'h1;
   localparam logic [1:0] off_emergency = 2'h2;

   // fault index: 5 ramp follow, 4 thermal, 3 current, 2 low, 1 excess, 0 phase
   typedef struct packed {
      logic ramp_follow;
      logic thermal;
      logic excess_current;
      logic low_output;
      logic excess_output;
      logic phase_leg;
   } fault_vec_t;

   typedef struct packed {
      logic [1:0] thermal;
      logic [1:0] low_output;
      logic [1:0] excess_output;
   } off_style_t;

   typedef struct packed {
      logic high_side_en;
      logic low_side_force;
      logic ramp_down;
      logic output_on;
   } drive_t;

   typedef enum logic [3:0] {
      st_off = 4'b0001,
      st_run = 4'b0010,
      st_fault_wait = 4'b0100,
      st_latched = 4'b1000
   } pwr_state_t;
endpackage : fault_regs_pkg

// file: design/fault_config_status_regs.sv
// fault configuration, status flags and turn-off control of the converter
//
// Operation
// R1: the ramp-follow check counts only while bit 7 of the latch config is one.
// R2: the phase voltage check counts only while bit 6 of the latch config is one.
// R3: config bits 5..0 pick latching or not for ramp, thermal, current, low, excess, phase.
// R4: thermal, low-output and excess-output events each have their own turn-off style.
// R5: sequenced turn-off ramps the output down at the programmed falling rate.
// R6: critical turn-off releases both high and low side drives at once.
// R7: emergency turn-off drops the high side and turns the low side on together.
// R8: every protection state is kept in the flags register at address 0x16.
// R9: flags bits 7..0 are thermal warn, good warn, ramp, thermal, current, low, excess, phase.
// R10: writing one to a fault bit clears that latched fault.
// R11: the two warning bits are read-only.
// R12: the power manager reads the flags register to monitor the group.
// R13: a detected fault turns the device off and reads as zero in its flag.
// R14: a non-latching fault retries start-up every 130 ms until it is gone.
// R15: a latching fault stays off; restart after 130 ms needs clear, turn-on recycle or input recycle; here every restart needs the flag cleared.
`timescale 1ns/1ps
module fault_config_status_regs
   import fault_regs_pkg::*;
#(
   parameter int retry_count = retry_cycles
) (
   input wire logic sys_clk,
   input wire logic nrst,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [7:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   output logic [7:0] reg_rdata,
   input wire fault_regs_pkg::off_style_t off_style,
   input wire fault_regs_pkg::fault_vec_t fault_cond,
   input wire logic thermal_warn_cond,
   input wire logic output_good_cond,
   input wire logic turn_on,
   input wire logic input_recycle,
   output fault_regs_pkg::drive_t drive
);
   import fault_regs_pkg::*;

   logic [7:0] cfg_r, cfg_nxt;
   logic [5:0] flt_r, flt_nxt;
   logic [1:0] warn_r, warn_nxt;
   logic [7:0] rdata_r, rdata_nxt;
   pwr_state_t st_r, st_nxt;
   logic [31:0] cnt_r, cnt_nxt;
   drive_t drv_r, drv_nxt;
   logic turn_on_d_r;
   logic [5:0] active;
   logic [5:0] clear_req;
   logic [5:0] latching;
   logic latched_any;
   // decode and restart helpers
   logic wr_flags, wr_cfg;
   logic retry_done;
   logic restart_ok;

   // which style applies: thermal first, then excess output, then low output
   function automatic logic [1:0] style_of(input logic [5:0] f, input off_style_t s);
      if (f[4]) style_of = s.thermal;
      else if (f[1]) style_of = s.excess_output;
      else if (f[2]) style_of = s.low_output;
      // faults without a style of their own stop hard
      else if (f[5] || f[3] || f[0]) style_of = off_critical;
      else style_of = off_sequenced;
   endfunction : style_of

   // switch drive pattern for each turn-off style
   function automatic drive_t off_drive(input logic [1:0] style);
      off_drive = '0;
      case (style)
         off_critical: begin
            off_drive.high_side_en = 1'b0; // R6
            off_drive.low_side_force = 1'b0; // R6
         end
         off_emergency: begin
            off_drive.high_side_en = 1'b0; // R7
            off_drive.low_side_force = 1'b1; // R7
         end
         default: begin
            // high side stays under the ramp controller while it winds down
            off_drive.high_side_en = 1'b1; // R5
            off_drive.ramp_down = 1'b1; // R5
         end
      endcase
      off_drive.output_on = 1'b0;
   endfunction : off_drive

   // drive pattern of a running output
   function automatic drive_t run_drive();
      run_drive = '0;
      run_drive.high_side_en = 1'b1;
      run_drive.output_on = 1'b1;
   endfunction : run_drive

   // register decode used by the write strobes
   function automatic logic addr_hit(input logic [7:0] a, input logic [7:0] target);
      addr_hit = (a == target);
   endfunction : addr_hit

   // gated fault view, latching mask, register decode
   always_comb begin
      // disabled checks never reach the flags or the state machine
      active = fault_cond;
      active[5] = fault_cond.ramp_follow & cfg_r[rfc_enable_bit]; // R1
      active[0] = fault_cond.phase_leg & cfg_r[phase_enable_bit]; // R2
      latching = cfg_r[5:0]; // R3
      wr_flags = reg_wr && addr_hit(reg_addr, flags_addr);
      wr_cfg = reg_wr && addr_hit(reg_addr, latch_cfg_addr);
      // a write of one to a flag bit asks to clear it
      clear_req = wr_flags ? reg_wdata[5:0] : 6'h00; // R10
      latched_any = |(~flt_r & latching);
      // retry window over, nothing latched and nothing present
      retry_done = (cnt_r >= 32'(retry_count - 1));
      restart_ok = retry_done && !latched_any && !(|active);
   end

   // register file and flags
   always_comb begin
      cfg_nxt = cfg_r;
      if (wr_cfg) cfg_nxt = reg_wdata;
      // active-low flags; a fault set wins over a clear
      for (int i = 0; i < 6; i++) begin
         flt_nxt[i] = flt_r[i];
         if (clear_req[i] || !latching[i]) flt_nxt[i] = 1'b1; // R10
         if (active[i]) flt_nxt[i] = 1'b0; // R13
      end
      // warnings follow their conditions, inverted; writes never reach them
      warn_nxt = {~thermal_warn_cond, ~output_good_cond}; // R11
      // read data is registered and stands until the next read
      rdata_nxt = rdata_r;
      if (reg_rd) begin
         case (reg_addr)
            flags_addr: rdata_nxt = {warn_r, flt_r}; // R8 R9 R12
            latch_cfg_addr: rdata_nxt = cfg_r;
            // unmapped addresses read as zero
            default: rdata_nxt = 8'h00;
         endcase
      end
   end

   // power state and turn-off drive
   always_comb begin
      st_nxt = st_r;
      cnt_nxt = cnt_r;
      drv_nxt = drv_r;
      case (st_r)
         st_off: begin
            drv_nxt = '0;
            // a latched flag or a present fault keeps the output down
            if (turn_on && !latched_any && !(|active)) begin
               st_nxt = st_run;
               drv_nxt = run_drive();
            end
         end
         st_run: begin
            // the first fault seen picks the style
            if (|active) begin // R13
               cnt_nxt = 32'h0;
               st_nxt = (|(active & latching)) ? st_latched : st_fault_wait; // R15 R14
               drv_nxt = off_drive(style_of(active, off_style)); // R4
            end else if (!turn_on) begin
               // plain turn-off command ramps down
               st_nxt = st_off;
               drv_nxt = off_drive(off_sequenced); // R5
            end
         end
         st_fault_wait: begin
            // hiccup: wait the full retry time, then try again if clear
            if (!retry_done) cnt_nxt = cnt_r + 32'h1;
            else if (!(|active)) st_nxt = st_off; // R14
            else cnt_nxt = 32'h0;
         end
         st_latched: begin
            if (!retry_done) cnt_nxt = cnt_r + 32'h1;
            // recycle of input or turn-on releases at once
            // after the retry time a cleared flag also releases
            if (input_recycle || (turn_on && !turn_on_d_r) || restart_ok)
               st_nxt = st_off; // R15
         end
         default: st_nxt = st_off;
      endcase
   end

   // register group: config, flags, read data
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         cfg_r <= latch_cfg_reset;
         flt_r <= flags_reset[5:0];
         warn_r <= flags_reset[7:6];
         rdata_r <= 8'h00;
      end else begin
         cfg_r <= cfg_nxt;
         flt_r <= flt_nxt;
         warn_r <= warn_nxt;
         rdata_r <= rdata_nxt;
      end
   end

   // power group: state, retry counter, switch drives
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         st_r <= st_off;
         cnt_r <= 32'h0;
         drv_r <= '0;
         turn_on_d_r <= 1'b0;
      end else begin
         st_r <= st_nxt;
         cnt_r <= cnt_nxt;
         drv_r <= drv_nxt;
         // previous turn-on level for the recycle edge
         turn_on_d_r <= turn_on;
      end
   end

   // outputs straight from flip-flops
   assign reg_rdata = rdata_r;
   assign drive = drv_r;
endmodule : fault_config_status_regs

// file: verification/fault_regs_props.sv
// checker on the fault register ports
`timescale 1ns/1ps
module fault_regs_props
   import fault_regs_pkg::*;
(
   input wire logic sys_clk,
   input wire logic nrst,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [7:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic [7:0] reg_rdata,
   input wire fault_regs_pkg::off_style_t off_style,
   input wire fault_regs_pkg::fault_vec_t fault_cond,
   input wire logic turn_on,
   input wire fault_regs_pkg::drive_t drive
);
   logic [1:0] en_r;
   default clocking @(posedge sys_clk); endclocking
   default disable iff (!nrst);
   // copy of the two check enables
   always_ff @(posedge sys_clk or negedge nrst)
      if (!nrst) en_r <= latch_cfg_reset[7:6];
      else if (reg_wr && reg_addr == latch_cfg_addr) en_r <= reg_wdata[7:6];
   a_fault_off: assert property (|fault_cond[4:1] && drive.output_on
      |=> !drive.output_on) else $error("fault left output on");
   a_emerg_drive: assert property (drive.output_on && fault_cond == 6'h10
      && off_style.thermal == off_emergency |=> drive == 4'h4) else $error("bad emergency");
   a_crit_drive: assert property (drive.output_on && fault_cond == 6'h08
      |=> drive == 4'h0) else $error("bad critical");
   a_seq_drive: assert property (drive.output_on && fault_cond == 6'h10
      && off_style.thermal == off_sequenced |=> drive == 4'ha) else $error("bad sequenced");
   a_checks_gated: assert property (turn_on && en_r == 2'h0 && fault_cond[4:1] == 4'h0
      && drive.output_on |=> drive.output_on) else $error("disabled check acted");
   a_unmapped_zero: assert property (reg_rd && reg_addr != flags_addr
      && reg_addr != latch_cfg_addr |=> reg_rdata == 8'h00) else $error("unmapped not zero");
   a_flag_zero: assert property (reg_rd && reg_addr == flags_addr && fault_cond.thermal
      && $past(fault_cond.thermal) |=> !reg_rdata[4]) else $error("flag not zero");
   a_rdata_holds: assert property (!reg_rd |=> $stable(reg_rdata))
      else $error("read data moved");
endmodule : fault_regs_props
bind fault_config_status_regs fault_regs_props props (.*);

// file: verification/power_manager_model.sv
// power manager model: reads and writes over the strobe bus
`timescale 1ns/1ps
module power_manager_model (
   input wire logic sys_clk,
   input wire logic [7:0] reg_rdata,
   output logic reg_wr = 1'b0,
   output logic reg_rd = 1'b0,
   output logic [7:0] reg_addr = 8'h00,
   output logic [7:0] reg_wdata = 8'h00
);
   task acc(input logic w, input logic [7:0] a, input logic [7:0] d, output logic [7:0] r);
      reg_wr <= w;
      reg_rd <= !w;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge sys_clk);
      reg_wr <= 1'b0;
      reg_rd <= 1'b0;
      reg_addr <= ~a;
      reg_wdata <= ~d;
      // read data stands from the taking edge until the next read
      @(posedge sys_clk);
      r = reg_rdata;
   endtask : acc
endmodule : power_manager_model

// file: verification/fault_config_status_regs_tb.sv
// bench for the fault register bank
`timescale 1ns/1ps
module fault_config_status_regs_tb;
   import fault_regs_pkg::*;
   logic sys_clk = 1'b0, nrst = 1'b0, turn_on = 1'b0, input_recycle = 1'b0;
   logic thermal_warn_cond = 1'b0, output_good_cond = 1'b1, reg_wr, reg_rd;
   logic [7:0] reg_addr, reg_wdata, reg_rdata, q;
   off_style_t off_style = 6'h00;
   fault_vec_t fault_cond = 6'h00;
   drive_t drive;
   int mismatches = 0, comparisons = 0;
   fault_config_status_regs #(.retry_count(20)) dut (.*);
   power_manager_model pm (.*);
   task chk(input logic [7:0] g, input logic [7:0] e);
      comparisons++;
      if (g !== e) begin
         mismatches++;
         $display("wrong value at %0t: %h not %h", $time, g, e);
      end
   endtask : chk
   task rd(input logic [7:0] a, input logic [7:0] e);
      pm.acc(1'b0, a, 8'h00, q);
      chk(q, e);
   endtask : rd
   task finish_test;
      $display("mismatches %0d comparisons %0d", mismatches, comparisons);
      if (mismatches == 0 && comparisons > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask : finish_test
   initial forever #5 sys_clk = ~sys_clk;
   initial begin
      #60000;
      mismatches++;
      finish_test;
   end
   initial begin
      repeat (16) @(posedge sys_clk);
      nrst <= 1'b1;
      @(posedge sys_clk);
      rd(latch_cfg_addr, 8'h7f);
      rd(flags_addr, 8'hbf);
      pm.acc(1'b1, flags_addr, 8'hc0, q);
      rd(flags_addr, 8'hbf);
      rd(8'h05, 8'h00);
      turn_on <= 1'b1;
      repeat (30) @(posedge sys_clk);
      for (int i = 0; i < 4; i++) begin
         off_style <= {i[1:0], 4'h0};
         fault_cond <= i < 3 ? 6'h10 : 6'h08;
         repeat (2) @(posedge sys_clk);
         chk({4'h0, drive}, i == 0 ? 8'h0a : i == 2 ? 8'h04 : 8'h00);
         rd(flags_addr, i < 3 ? 8'haf : 8'hb7);
         fault_cond <= 6'h00;
         pm.acc(1'b1, flags_addr, 8'h3f, q);
         input_recycle <= 1'b1;
         @(posedge sys_clk);
         input_recycle <= 1'b0;
         repeat (30) @(posedge sys_clk);
         rd(flags_addr, 8'hbf);
         chk({7'h0, drive.output_on}, 8'h01);
      end
      pm.acc(1'b1, latch_cfg_addr, 8'hc0, q);
      fault_cond <= 6'h04;
      repeat (5) @(posedge sys_clk);
      rd(flags_addr, 8'hbb);
      fault_cond <= 6'h00;
      repeat (60) @(posedge sys_clk);
      rd(flags_addr, 8'hbf);
      chk({7'h0, drive.output_on}, 8'h01);
      pm.acc(1'b1, latch_cfg_addr, 8'h3f, q);
      fault_cond <= 6'h21;
      repeat (5) @(posedge sys_clk);
      rd(flags_addr, 8'hbf);
      pm.acc(1'b1, latch_cfg_addr, 8'hc0, q);
      repeat (2) @(posedge sys_clk);
      rd(flags_addr, 8'h9e);
      fault_cond <= 6'h00;
      repeat (3) @(posedge sys_clk);
      thermal_warn_cond <= 1'b1;
      output_good_cond <= 1'b0;
      repeat (3) @(posedge sys_clk);
      rd(flags_addr, 8'h7f);
      finish_test;
   end
endmodule : fault_config_status_regs_tb
